/* File: logic/tdcr_regs.sv */
// register bank of one time-to-digital converter core, apb slave
//
// Contract
// - bits 7:6 pick second calibration length: 2, 10, 20 or 40 periods.
// - bits 5:3 pick averaging cycles as two to the power of code.
// - bits 2:0 pick one to five stops for codes 000 to 100.
// - stop codes 101, 110 and 111 behave like single stop.
// - flag bit 4 sets on measurement finish; writing one clears it.
// - flag bit 3 sets when start signal arrives; writing one clears.
// - reference clock overflow sets bit 2, stops measurement, write one clears.
// - coarse overflow sets bit 1, stops measurement, write one clears.
// - new result sets bit 0 until host writes one to it.
// - enable bit 2 gates reference clock overflow onto interrupt; resets one.
// - enable bit 1 gates coarse overflow onto interrupt; resets one.
// - enable bit 0 gates new result onto interrupt; resets one.
// - disabled sources keep their flags set and readable.
// - enable register resets to 07h, upper five bits zero.
// - coarse threshold is 16 bits at 04h high, 05h low, reset FFh.
// - flag register resets 00h; bits 7:5 are plain storage.
// - writing begin bit clears all flag bits before measuring.
// - reference clock threshold is 16 bits, high byte at 06h.
`timescale 1ns/1ps

module tdcr_regs
    import tdcr_pkg::*;
(
    input wire logic SYS_CLK, // 50 MHz system clock
    input wire logic SRST, // synchronous reset, active high
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb access phase
    input wire logic PWRITE, // apb direction, high for write
    input wire logic [7:0] PADDR, // apb byte address
    input wire logic [31:0] PWDATA, // apb write data
    output logic PREADY, // apb ready
    output logic [31:0] PRDATA, // apb read data
    output logic PSLVERR, // apb error on unmapped address
    input wire tdcr_events_s EVENTS, // measurement engine events
    output tdcr_setup_s SETUP, // decoded settings
    output logic MEAS_BEGIN, // one-cycle trigger of a measurement
    output logic MEAS_ABORT, // stop the running measurement
    output logic IRQ_N // interrupt pin, active low
);

    function automatic logic hits(input logic [7:0] addr,
                                  input logic [7:0] idx);
        hits = (addr == 8'(idx * ADDR_SCALE));
    endfunction

    function automatic logic [5:0] cal_count(input logic [1:0] code);
        case (code)
            2'b00: cal_count = 6'd2;
            2'b01: cal_count = 6'd10;
            2'b10: cal_count = 6'd20;
            default: cal_count = 6'd40;
        endcase
    endfunction

    function automatic logic [2:0] stop_count(input logic [2:0] code);
        if (code <= 3'b100) begin
            stop_count = code + 3'd1;
        end else begin
            stop_count = 3'd1;
        end
    endfunction

    tdcr_bus_e bus_state;
    logic [7:0] setup_two;
    logic [7:0] flags;
    logic [7:0] enable;
    logic [7:0] coarse_high;
    logic [7:0] coarse_low;
    logic [7:0] refclk_high;
    logic [7:0] refclk_low;
    logic pending;

    // address decode
    wire hit_setup = hits(PADDR, IDX_SETUP_TWO);
    wire hit_flags = hits(PADDR, IDX_FLAGS);
    wire hit_enable = hits(PADDR, IDX_ENABLE);
    wire hit_c_high = hits(PADDR, IDX_COARSE_HIGH);
    wire hit_c_low = hits(PADDR, IDX_COARSE_LOW);
    wire hit_r_high = hits(PADDR, IDX_REFCLK_HIGH);
    wire hit_r_low = hits(PADDR, IDX_REFCLK_LOW);
    wire hit_control = hits(PADDR, IDX_CONTROL);
    wire mapped = hit_setup | hit_flags | hit_enable | hit_c_high
        | hit_c_low | hit_r_high | hit_r_low | hit_control;

    // a write lands at the edge closing the access phase
    wire commit = PSEL & PENABLE & PREADY;
    wire wr = commit & PWRITE & mapped;
    wire wr_flags = wr & hit_flags;
    wire begin_wr = wr & hit_control & PWDATA[BIT_BEGIN];

    // read selection
    wire [7:0] rd_byte =
        hit_setup ? setup_two :
        hit_flags ? flags :
        hit_enable ? enable :
        hit_c_high ? coarse_high :
        hit_c_low ? coarse_low :
        hit_r_high ? refclk_high :
        hit_r_low ? refclk_low :
        hit_control ? {7'd0, pending} : 8'h00;

    // overflow detection while a measurement runs
    wire [15:0] coarse_thr = {coarse_high, coarse_low};
    wire [15:0] refclk_thr = {refclk_high, refclk_low};
    wire refclk_ovf = EVENTS.busy
        & (EVENTS.refclk_count >= refclk_thr);
    wire coarse_ovf = EVENTS.busy
        & (EVENTS.coarse_count >= coarse_thr);

    // hardware events that set flags
    wire [4:0] set_bits = {
        EVENTS.done,
        EVENTS.start_seen,
        refclk_ovf,
        coarse_ovf,
        EVENTS.done
    };

    // write one clears; a begin write clears everything
    wire [4:0] clr_bits =
        begin_wr ? 5'h1F :
        wr_flags ? PWDATA[4:0] : 5'h00;

    // set wins over a clear in the same cycle
    wire [4:0] next_events = (flags[4:0] & ~clr_bits) | set_bits;

    wire [2:0] next_reserved =
        begin_wr ? 3'b000 :
        wr_flags ? PWDATA[7:5] : flags[7:5];

    // flags stay set whatever the enables say
    wire [2:0] live = flags[2:0] & enable[2:0];
    wire next_irq_n = ~(|live);

    wire next_pending = begin_wr
        | (pending & ~EVENTS.done & ~refclk_ovf & ~coarse_ovf);

    // bus answer: ready rises in the access phase, one answer each
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            bus_state <= BUS_SETUP;
            PREADY <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else begin
            case (bus_state)
                BUS_SETUP: begin
                    if (PSEL & ~PENABLE) begin
                        bus_state <= BUS_ANSWER;
                        PREADY <= 1'b1;
                        PRDATA <= {24'h00_0000, rd_byte};
                        PSLVERR <= ~mapped;
                    end
                end
                BUS_ANSWER: begin
                    bus_state <= BUS_SETUP;
                    PREADY <= 1'b0;
                    PSLVERR <= 1'b0;
                end
                default: begin
                    bus_state <= BUS_SETUP;
                    PREADY <= 1'b0;
                end
            endcase
        end
    end

    // configuration storage
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            setup_two <= RST_SETUP_TWO;
            enable <= RST_ENABLE;
            coarse_high <= RST_THRESHOLD;
            coarse_low <= RST_THRESHOLD;
            refclk_high <= RST_THRESHOLD;
            refclk_low <= RST_THRESHOLD;
        end else begin
            if (wr & hit_setup) begin
                setup_two <= PWDATA[7:0];
            end
            if (wr & hit_enable) begin
                enable <= PWDATA[7:0];
            end
            if (wr & hit_c_high) begin
                coarse_high <= PWDATA[7:0];
            end
            if (wr & hit_c_low) begin
                coarse_low <= PWDATA[7:0];
            end
            if (wr & hit_r_high) begin
                refclk_high <= PWDATA[7:0];
            end
            if (wr & hit_r_low) begin
                refclk_low <= PWDATA[7:0];
            end
        end
    end

    // status flags and measurement control
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            flags <= RST_FLAGS;
            pending <= 1'b0;
            MEAS_BEGIN <= 1'b0;
            MEAS_ABORT <= 1'b0;
            IRQ_N <= 1'b1;
        end else begin
            flags <= {next_reserved, next_events};
            pending <= next_pending;
            MEAS_BEGIN <= begin_wr;
            MEAS_ABORT <= refclk_ovf | coarse_ovf;
            IRQ_N <= next_irq_n;
        end
    end

    // decoded settings toward the engine
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            SETUP <= '0;
        end else begin
            SETUP.cal_periods <=
                cal_count(setup_two[CAL_LSB +: 2]);
            SETUP.averaging_count <=
                8'(1) << setup_two[AVG_LSB +: 3];
            SETUP.stop_count <=
                stop_count(setup_two[STOP_LSB +: 3]);
            SETUP.coarse_threshold <= coarse_thr;
            SETUP.refclk_threshold <= refclk_thr;
        end
    end

endmodule

/* File: pkg/tdcr_pkg.sv */
// constants and carrier types of the converter core register bank
package tdcr_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_SETUP_TWO = 8'h01;
    localparam logic [7:0] IDX_FLAGS = 8'h02;
    localparam logic [7:0] IDX_ENABLE = 8'h03;
    localparam logic [7:0] IDX_COARSE_HIGH = 8'h04;
    localparam logic [7:0] IDX_COARSE_LOW = 8'h05;
    localparam logic [7:0] IDX_REFCLK_HIGH = 8'h06;
    localparam logic [7:0] IDX_REFCLK_LOW = 8'h07;
    localparam logic [7:0] IDX_CONTROL = 8'h1F;
    localparam int unsigned ADDR_SCALE = 4;

    // values after reset
    localparam logic [7:0] RST_SETUP_TWO = 8'h40;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_ENABLE = 8'h07;
    localparam logic [7:0] RST_THRESHOLD = 8'hFF;

    // field positions in measurement_setup_two
    localparam int unsigned CAL_LSB = 6;
    localparam int unsigned AVG_LSB = 3;
    localparam int unsigned STOP_LSB = 0;

    // bit positions in interrupt_flags and interrupt_enable, and of the begin bit in the control register
    localparam int unsigned BIT_FINISHED = 4;
    localparam int unsigned BIT_BEGUN = 3;
    localparam int unsigned BIT_REFCLK_OVF = 2;
    localparam int unsigned BIT_COARSE_OVF = 1;
    localparam int unsigned BIT_FRESH = 0;
    localparam int unsigned BIT_BEGIN = 0;

    // events from the measurement engine, same clock
    typedef struct packed {
        logic start_seen;
        logic done;
        logic busy;
        logic [15:0] refclk_count;
        logic [15:0] coarse_count;
    } tdcr_events_s;

    // decoded settings toward the measurement engine
    typedef struct packed {
        logic [5:0] cal_periods;
        logic [7:0] averaging_count;
        logic [2:0] stop_count;
        logic [15:0] coarse_threshold;
        logic [15:0] refclk_threshold;
    } tdcr_setup_s;

    typedef enum logic {
        BUS_SETUP = 1'b0,
        BUS_ANSWER = 1'b1
    } tdcr_bus_e;

endpackage

/* File: testbench/tdcr_regs_props.sv */
// assertion checker for the converter core register bank
`timescale 1ns/1ps
module tdcr_regs_props
    import tdcr_pkg::*;
(
    input wire logic SYS_CLK, // clock
    input wire logic SRST, // reset
    input wire logic PSEL, // select
    input wire logic PENABLE, // access
    input wire logic PWRITE, // direction
    input wire logic [7:0] PADDR, // address
    input wire logic [31:0] PWDATA, // write data
    input wire logic PREADY, // ready
    input wire logic [31:0] PRDATA, // read data
    input wire logic PSLVERR, // error
    input wire tdcr_events_s EVENTS, // engine events
    input wire tdcr_setup_s SETUP, // settings
    input wire logic MEAS_BEGIN, // trigger
    input wire logic MEAS_ABORT, // abort
    input wire logic IRQ_N // interrupt
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (SRST);
    logic [2:0] en;
    wire wr = PSEL && PENABLE && PREADY && PWRITE;
    wire c_ovf = EVENTS.busy && EVENTS.coarse_count >= SETUP.coarse_threshold;
    wire r_ovf = EVENTS.busy && EVENTS.refclk_count >= SETUP.refclk_threshold;
    // shadow of the enable register
    always_ff @(posedge SYS_CLK) begin
        if (SRST) en <= 3'h7;
        else if (wr && PADDR == 8'h0C) en <= PWDATA[2:0];
    end
    sequence s_begin; wr && PADDR == 8'h7C && PWDATA[0]; endsequence
    sequence s_fresh; EVENTS.done && en[0] ##1 en[0]; endsequence
    sequence s_ref; r_ovf && en[2] ##1 en[2]; endsequence
    property p_begin; s_begin |=> MEAS_BEGIN; endproperty
    property p_coarse; c_ovf |=> MEAS_ABORT; endproperty
    property p_refclk; r_ovf |=> MEAS_ABORT; endproperty
    property p_fresh; s_fresh |=> !IRQ_N; endproperty
    property p_refirq; s_ref |=> !IRQ_N; endproperty
    property p_mask; !IRQ_N |-> $past(en) != 3'h0; endproperty
    property p_cal; !$past(SRST) |->
        SETUP.cal_periods inside {6'h02, 6'h0A, 6'h14, 6'h28}; endproperty
    property p_stop; !$past(SRST) |->
        SETUP.stop_count inside {[3'h1:3'h5]}; endproperty
    a_begin: assert property (p_begin) else $error("no begin");
    a_coarse: assert property (p_coarse) else $error("coarse");
    a_refclk: assert property (p_refclk) else $error("refclk");
    a_fresh: assert property (p_fresh) else $error("fresh");
    a_refirq: assert property (p_refirq) else $error("ref irq");
    a_mask: assert property (p_mask) else $error("mask");
    a_cal: assert property (p_cal) else $error("cal");
    a_stop: assert property (p_stop) else $error("stop");
endmodule

bind tdcr_regs tdcr_regs_props i_tdcr_regs_props (.SYS_CLK, .SRST,
    .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PREADY, .PRDATA,
    .PSLVERR, .EVENTS, .SETUP, .MEAS_BEGIN, .MEAS_ABORT, .IRQ_N);

/* File: testbench/tdcr_engine_model.sv */
// behavioural measurement engine facing the register bank
`timescale 1ns/1ps
module tdcr_engine_model
    import tdcr_pkg::*;
#(
    parameter int DONE_AT = 20 // coarse count at which an uninterrupted run ends
)(
    input wire logic clk, // clock
    input wire logic srst, // reset
    input wire logic meas_begin, // trigger
    input wire logic meas_abort, // abort
    output tdcr_events_s ev // events
);
    always_ff @(posedge clk) begin
        ev.start_seen <= meas_begin;
        ev.done <= 1'b0;
        if (srst) begin
            ev <= '0;
        end else if (meas_begin) begin
            ev.busy <= 1'b1;
            ev.refclk_count <= 16'h0000;
            ev.coarse_count <= 16'h0000;
        end else if (ev.busy) begin
            ev.refclk_count <= ev.refclk_count + 16'h0001;
            ev.coarse_count <= ev.coarse_count + 16'h0001;
            if (meas_abort) begin
                ev.busy <= 1'b0;
            end else if (ev.coarse_count == 16'(DONE_AT)) begin
                ev.busy <= 1'b0;
                ev.done <= 1'b1;
            end
        end
    end
endmodule

/* File: testbench/tdcr_regs_tb.sv */
// self-checking bench of the converter core register bank
`timescale 1ns/1ps
module tdcr_regs_tb;
    import tdcr_pkg::*;
    logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, mbeg, mabt, irq_n, er;
    tdcr_events_s ev;
    tdcr_setup_s setup;
    int n_mismatch = 0, n_tests = 0;
    tdcr_regs i_tdcr_regs (.SYS_CLK(clk), .SRST(srst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
        .PSLVERR(pslverr), .EVENTS(ev), .SETUP(setup),
        .MEAS_BEGIN(mbeg), .MEAS_ABORT(mabt), .IRQ_N(irq_n));
    tdcr_engine_model i_tdcr_engine_model (.clk(clk), .srst(srst),
        .meas_begin(mbeg), .meas_abort(mabt), .ev(ev));
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic summarize;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        xfer(0, a, 0);
        chk(rd, exp);
    endtask
    // start a measurement and wait until the engine is idle again
    task automatic run;
        xfer(1, 8'h7C, 8'h01);
        do @(posedge clk); while (ev.busy !== 1'b1);
        do @(posedge clk); while (ev.busy === 1'b1);
        repeat (3) @(posedge clk);
    endtask
    task automatic t_reset;
        logic [7:0] a[6] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
        logic [7:0] v[6] = '{8'h40, 8'h00, 8'h07, 8'hFF, 8'hFF, 8'hFF};
        for (int i = 0; i < 6; i++) rdc(a[i], v[i]);
        xfer(0, 8'h20, 0);
        chk({er, rd[30:0]}, 32'h8000_0000);
    endtask
    task automatic t_setup;
        logic [5:0] cal[4] = '{6'h02, 6'h0A, 6'h14, 6'h28};
        for (int i = 0; i < 8; i++) begin
            xfer(1, 8'h04, {i[1:0], i[2:0], i[2:0]});
            repeat (2) @(posedge clk);
            chk({setup.cal_periods, setup.averaging_count, setup.stop_count},
                {cal[i%4], 8'(1 << i), 3'(i < 5 ? i + 1 : 1)});
            rdc(8'h04, {i[1:0], i[2:0], i[2:0]});
        end
    endtask
    task automatic t_flags;
        xfer(1, 8'h08, 8'hE0);
        rdc(8'h08, 8'hE0);
        run;
        rdc(8'h08, 8'h19);
        chk(irq_n, 1'h0);
        xfer(1, 8'h08, 8'h1F);
        rdc(8'h08, 8'h00);
        chk(irq_n, 1'h1);
        xfer(1, 8'h0C, 8'h00);
        run;
        rdc(8'h08, 8'h19);
        chk(irq_n, 1'h1);
        xfer(1, 8'h0C, 8'h07);
        repeat (2) @(posedge clk);
        chk(irq_n, 1'h0);
    endtask
    task automatic t_ovf;
        xfer(1, 8'h10, 8'h00);
        xfer(1, 8'h14, 8'h0C);
        repeat (2) @(posedge clk);
        chk({setup.coarse_threshold, setup.refclk_threshold},
            32'h000C_FFFF);
        run;
        rdc(8'h08, 8'h0A);
        chk(irq_n, 1'h0);
        xfer(1, 8'h0C, 8'h05);
        repeat (2) @(posedge clk);
        chk(irq_n, 1'h1);
        xfer(1, 8'h0C, 8'h07);
        xfer(1, 8'h14, 8'hFF);
        xfer(1, 8'h10, 8'hFF);
        xfer(1, 8'h18, 8'h00);
        xfer(1, 8'h1C, 8'h0C);
        run;
        rdc(8'h08, 8'h0C);
        chk(irq_n, 1'h0);
        chk({setup.coarse_threshold, setup.refclk_threshold},
            32'hFFFF_000C);
        xfer(1, 8'h08, 8'h04);
        rdc(8'h08, 8'h08);
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        summarize;
    end
    initial begin
        repeat (6) @(posedge clk);
        srst <= 0;
        t_reset;
        t_setup;
        t_flags;
        t_ovf;
        summarize;
    end
endmodule
